// ==== design/eee_pkg.sv ====
package eee_pkg;
    // ------------------------------------------------------------------
    // Register offsets (byte addresses on the host register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] EEE_OFF_RECOVERY = 8'hF2;
    localparam logic [7:0] EEE_OFF_NP_CTRL = 8'hF3;
    localparam logic [7:0] EEE_OFF_WAIT_LO = 8'hF4;
    localparam logic [7:0] EEE_OFF_WAIT_HI = 8'hF5;
    localparam logic [7:0] EEE_OFF_THRESH = 8'hF6;
    localparam logic [7:0] EEE_OFF_THRESH_HI = 8'hF7;
    localparam logic [7:0] EEE_OFF_STATUS_HI = 8'hF1;
    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] EEE_RST_RECOVERY = 8'h27;
    localparam logic [15:0] EEE_RST_WAIT = 16'h03E8;
    localparam logic [7:0] EEE_RST_THRESH = 8'h04;
    localparam logic [7:0] EEE_RST_NP_CTRL = 8'h02;
    localparam int EEE_NP_P2_BIT = 1;
    localparam int EEE_NP_P1_BIT = 0;
    localparam logic [7:0] EEE_NP_RW_MASK = 8'hC3;
    localparam int EEE_HW_EN_BIT = 6; // Bit 14 of 16-bit status, high byte
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int EEE_CLK_HZ = 40_000_000;
    localparam int EEE_RECOVERY_UNIT_NS = 640;
    localparam int EEE_RECOVERY_UNIT_CYC =
        (EEE_RECOVERY_UNIT_NS * (EEE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int EEE_WAIT_UNIT_US = 1300;
    localparam int EEE_WAIT_UNIT_CYC =
        EEE_WAIT_UNIT_US * (EEE_CLK_HZ / 1_000_000);
    localparam int EEE_THRESH_UNIT_BYTES = 128;
    localparam int EEE_NUM_PORTS = 3;
endpackage

// ==== design/eee_port_idle.sv ====
`timescale 1ns/1ps
// One port's empty-queue idle timer
module eee_port_idle
    import eee_pkg::*;
#(
    parameter int TICK_W = 16
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic queue_empty_i,
    input wire logic [TICK_W-1:0] wait_time_i,
    output logic lpi_req_o
);
    typedef struct packed {
        logic [TICK_W:0] count;
        logic req;
    } eee_idle_st_t;

    eee_idle_st_t st;
    eee_idle_st_t next_st;

    // --------------------------------------------------------------
    // Idle interval counting
    // --------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (!enable_i || !queue_empty_i) begin
            next_st.count = '0;
            next_st.req = 1'b0;
        end else if (tick_i && !st.req) begin
            // Exceeds means strictly longer than the setting
            if (st.count > {1'b0, wait_time_i}) begin
                next_st.req = 1'b1;
            end else begin
                next_st.count = st.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lpi_req_o = st.req;
endmodule // eee_port_idle

// ==== design/eee_lpi_timing_control.sv ====
`timescale 1ns/1ps
module eee_lpi_timing_control
    import eee_pkg::*;
#(
    parameter int WAIT_UNIT_CYC = EEE_WAIT_UNIT_CYC,
    parameter int RECOV_UNIT_CYC = EEE_RECOVERY_UNIT_CYC,
    parameter int LOAD_W = 16
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Host register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Auto-negotiation / PHY side
    input wire logic eee_hw_enabled_i,
    output logic p1_next_page_en_o,
    output logic p2_next_page_en_o,
    input wire logic p2_lpi_exit_i,
    output logic p2_tx_hold_o,
    // Queue and buffer state, one entry per port; lpi_terminate_o is one shared bit
    input wire logic [EEE_NUM_PORTS-1:0] transmit_queue_empty_i,
    input wire logic [EEE_NUM_PORTS*LOAD_W-1:0] buffer_load_i,
    output logic [EEE_NUM_PORTS-1:0] lpi_req_o,
    output logic lpi_terminate_o
);
    // Divider widths follow the unit lengths in cycles
    localparam int WU_W = $clog2(WAIT_UNIT_CYC + 1);
    localparam int RU_W = $clog2(RECOV_UNIT_CYC + 1);

    // All state in one record; the comb process builds its successor
    typedef struct packed {
        logic [7:0] recovery;
        logic [7:0] np_ctrl;
        logic [15:0] wait_time;
        logic [7:0] thresh;
        logic [WU_W-1:0] wait_div;
        logic [RU_W-1:0] rec_div;
        logic [7:0] rec_count;
        logic hold;
        logic terminate;
        logic [7:0] rdata;
    } eee_ctl_st_t;

    eee_ctl_st_t st;
    eee_ctl_st_t next_st;
    logic wait_tick;
    logic rec_unit_end;
    logic [7:0] status_hi;
    logic [EEE_NUM_PORTS-1:0] over;

    // --------------------------------------------------------------
    // Per-port buffer load compare
    // --------------------------------------------------------------
    // Load counted in bytes; threshold scaled by the 128-byte unit
    genvar gi;
    generate
        for (gi = 0; gi < EEE_NUM_PORTS; gi++) begin : g_port
            logic [LOAD_W+7:0] limit;
            // Widened so 255 units of 128 bytes cannot wrap
            assign limit = (LOAD_W + 8)'(st.thresh) *
                (LOAD_W + 8)'(EEE_THRESH_UNIT_BYTES);
            assign over[gi] = (LOAD_W + 8)'(
                buffer_load_i[gi*LOAD_W +: LOAD_W]) > limit;
            // One idle timer per port, all fed one tick and one setting
            eee_port_idle #(
                .TICK_W(16)
            ) u_idle (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .tick_i(wait_tick),
                .enable_i(eee_hw_enabled_i),
                .queue_empty_i(transmit_queue_empty_i[gi]),
                .wait_time_i(st.wait_time),
                .lpi_req_o(lpi_req_o[gi])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // Shared strobes and status byte
    // --------------------------------------------------------------
    // One divider feeds all three idle timers, so one wait setting
    // means the same interval on every port
    assign wait_tick = (st.wait_div == WU_W'(WAIT_UNIT_CYC - 1));
    // Last cycle of a recovery unit while the hold runs
    assign rec_unit_end = st.hold &&
        (st.rec_div == RU_W'(RECOV_UNIT_CYC - 1));
    // Only the hardware EEE enable is kept; the other status bits of
    // this byte belong to the PCS and read zero here
    assign status_hi = 8'(eee_hw_enabled_i) << EEE_HW_EN_BIT;

    // --------------------------------------------------------------
    // Registers, dividers and recovery hold
    // --------------------------------------------------------------
    // Next state of the whole record; every field defaults to its
    // present value, so each branch names only what it changes
    always_comb begin
        next_st = st;
        // Shared 1.3 ms divider, free running from reset
        next_st.wait_div = wait_tick ? '0 : st.wait_div + 1'b1;
        // Registered so a one-cycle load spike still ends LPI cleanly
        next_st.terminate = |over;
        // Recovery hold after LPI exit on port 2
        if (p2_lpi_exit_i) begin
            // A fresh exit restarts the wait from the full count
            next_st.hold = (st.recovery != 8'h00);
            next_st.rec_count = st.recovery;
            next_st.rec_div = '0;
        end else if (rec_unit_end) begin
            // One 640 ns unit is over
            next_st.rec_div = '0;
            next_st.rec_count = st.rec_count - 8'h01;
            if (st.rec_count == 8'h01) begin
                next_st.hold = 1'b0;
            end
        end else if (st.hold) begin
            next_st.rec_div = st.rec_div + 1'b1;
        end
        // Register writes; read-only and unmapped offsets are ignored
        if (reg_wr_i) begin
            case (reg_addr_i)
                EEE_OFF_RECOVERY: begin
                    // Count is taken at the next exit, not mid-hold
                    next_st.recovery = reg_wdata_i;
                end
                EEE_OFF_NP_CTRL: begin
                    // Bits 5:2 are read-only zero
                    next_st.np_ctrl = reg_wdata_i & EEE_NP_RW_MASK;
                end
                EEE_OFF_WAIT_LO: begin
                    // Bytes land one at a time; a timer may briefly see a
                    // mixed value, so change it while the queues are busy
                    next_st.wait_time[7:0] = reg_wdata_i;
                end
                EEE_OFF_WAIT_HI: begin
                    next_st.wait_time[15:8] = reg_wdata_i;
                end
                EEE_OFF_THRESH: begin
                    next_st.thresh = reg_wdata_i;
                end
                default: begin
                    // Threshold high byte is reserved and keeps zero
                end
            endcase
        end
        // Registered read data; unmapped offsets read zero
        if (reg_rd_i) begin
            case (reg_addr_i)
                EEE_OFF_STATUS_HI: begin
                    next_st.rdata = status_hi;
                end
                EEE_OFF_RECOVERY: begin
                    next_st.rdata = st.recovery;
                end
                EEE_OFF_NP_CTRL: begin
                    next_st.rdata = st.np_ctrl;
                end
                EEE_OFF_WAIT_LO: begin
                    next_st.rdata = st.wait_time[7:0];
                end
                EEE_OFF_WAIT_HI: begin
                    next_st.rdata = st.wait_time[15:8];
                end
                EEE_OFF_THRESH: begin
                    next_st.rdata = st.thresh;
                end
                EEE_OFF_THRESH_HI: begin
                    next_st.rdata = 8'h00;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    // Reset loads constants only; everything else starts at zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Clear all, then the non-zero register reset values
            st <= '0;
            st.recovery <= EEE_RST_RECOVERY;
            st.np_ctrl <= EEE_RST_NP_CTRL;
            st.wait_time <= EEE_RST_WAIT;
            st.thresh <= EEE_RST_THRESH;
        end else begin
            st <= next_st;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // Enables follow the register from the cycle after the write, even mid-link
    assign p2_next_page_en_o = st.np_ctrl[EEE_NP_P2_BIT];
    assign p1_next_page_en_o = st.np_ctrl[EEE_NP_P1_BIT];
    // Flop outputs, so the MAC and the ports see no decode glitches
    assign p2_tx_hold_o = st.hold;
    assign lpi_terminate_o = st.terminate;
    // Read data stands until the next read strobe
    assign reg_rdata_o = st.rdata;
endmodule // eee_lpi_timing_control

// ==== test/eee_props.sv ====
`timescale 1ns/1ps
module eee_props (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic eee_hw_enabled_i,
    input wire logic p1_next_page_en_o,
    input wire logic p2_next_page_en_o,
    input wire logic p2_lpi_exit_i,
    input wire logic p2_tx_hold_o,
    input wire logic [2:0] transmit_queue_empty_i,
    input wire logic [47:0] buffer_load_i,
    input wire logic [2:0] lpi_req_o,
    input wire logic lpi_terminate_o
);
    // Write to the next page control byte
    wire np_wr = reg_wr_i && reg_addr_i == 8'hF3;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Hold rises only after an exit; enables move only on a write, then follow the written bits
    chk_hold_cause: assert property ($rose(p2_tx_hold_o) |->
        $past(p2_lpi_exit_i)) else $error("hold without exit");
    chk_np2_write: assert property (np_wr |=>
        p2_next_page_en_o == $past(reg_wdata_i[1])) else $error("np2 bad");
    chk_np1_write: assert property (np_wr |=>
        p1_next_page_en_o == $past(reg_wdata_i[0])) else $error("np1 bad");
    chk_np_held: assert property ($changed({p1_next_page_en_o,
        p2_next_page_en_o}) |-> $past(np_wr)) else $error("np moved");
    // Requests need a queue that stayed empty and EEE in force
    chk_req_queue: assert property (1'b1 |->
        (lpi_req_o & ~$past(transmit_queue_empty_i)) == 3'h0)
        else $error("req with busy queue");
    chk_req_enable: assert property (|lpi_req_o |->
        $past(eee_hw_enabled_i)) else $error("req without eee");
    chk_term_idle: assert property (buffer_load_i == 48'h0 |=>
        !lpi_terminate_o) else $error("terminate with empty buffers");
    chk_status_read: assert property (reg_rd_i && reg_addr_i == 8'hF1
        |=> reg_rdata_o == {1'b0, $past(eee_hw_enabled_i), 6'h00})
        else $error("status byte bad");
endmodule // eee_props

bind eee_lpi_timing_control eee_props chk_u (.*);

// ==== test/eee_link_partner.sv ====
`timescale 1ns/1ps
module eee_link_partner (
    input wire logic clk_i,
    input wire logic np_en_i,
    input wire logic able_i,
    input wire logic wake_i,
    output logic eee_on_o = 1'b0,
    output logic exit_o = 1'b0
);
    // EEE agreed only if our side runs next pages; wake ends LPI
    always_ff @(posedge clk_i) begin
        // Agreement is re-run every cycle, as if after a restart
        eee_on_o <= np_en_i && able_i;
        exit_o <= wake_i;
    end
endmodule // eee_link_partner

// ==== test/eee_lpi_timing_control_tb_top.sv ====
`timescale 1ns/1ps
module eee_lpi_timing_control_tb_top;
    logic clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
    logic eee_hw_enabled_i, p1_next_page_en_o, p2_next_page_en_o;
    logic p2_lpi_exit_i, p2_tx_hold_o, lpi_terminate_o, able = 1, wake = 0;
    logic [2:0] transmit_queue_empty_i = 0, lpi_req_o;
    logic [47:0] buffer_load_i = 0;
    int err_total = 0, compares = 0, cyc = 0, n;
    always #12.5 clk_i = ~clk_i;
    // Short units keep timer runs to tens of cycles
    eee_lpi_timing_control #(.WAIT_UNIT_CYC(4), .RECOV_UNIT_CYC(2)) dut_u (.*);
    eee_link_partner lp_u (.clk_i, .np_en_i(p2_next_page_en_o),
        .able_i(able), .wake_i(wake), .eee_on_o(eee_hw_enabled_i),
        .exit_o(p2_lpi_exit_i));
    task chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobes span one rising edge, set and cleared on falling edges
    task wr(input logic [7:0] a, d);
        @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(negedge clk_i) reg_wr_i = 0;
    endtask
    task rd(input logic [7:0] a, e);
        @(negedge clk_i) {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i) reg_rd_i = 0;
        chk(reg_rdata_o, e);
    endtask
    task conclude;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task t_reset;
        chk({p2_next_page_en_o, p1_next_page_en_o}, 2'b10);
        rd(8'hF2, 8'h27);
        rd(8'hF3, 8'h02);
        rd(8'hF4, 8'hE8);
        rd(8'hF5, 8'h03);
        rd(8'hF6, 8'h04);
        rd(8'hF1, 8'h40);
        rd(8'hF8, 8'h00);
        $display("reset values done");
    endtask
    task t_np;
        wr(8'hF3, 8'hFF);
        rd(8'hF3, 8'hC3);
        chk({p2_next_page_en_o, p1_next_page_en_o}, 2'b11);
        wr(8'hF3, 8'h00);
        rd(8'hF1, 8'h00);
        wr(8'hF3, 8'h02);
        $display("next page done");
    endtask
    // Hold must last exactly count units; zero count means none
    task t_recov;
        for (int i = 0; i < 2; i++) begin
            wr(8'hF2, i ? 8'h03 : 8'h00);
            @(negedge clk_i) wake = 1;
            @(negedge clk_i) wake = 0;
            n = 0;
            repeat (20) @(negedge clk_i) n += p2_tx_hold_o;
            chk(n, i ? 6 : 0);
        end
        $display("recovery done");
    endtask
    task t_idle;
        wr(8'hF4, 8'h02);
        wr(8'hF5, 8'h00);
        @(negedge clk_i) transmit_queue_empty_i = 3'h7;
        repeat (8) @(negedge clk_i);
        chk(lpi_req_o, 3'h0);
        repeat (12) @(negedge clk_i);
        chk(lpi_req_o, 3'h7);
        @(negedge clk_i) transmit_queue_empty_i = 3'h6;
        @(negedge clk_i) chk(lpi_req_o, 3'h6);
        able = 0;
        repeat (3) @(negedge clk_i);
        chk(lpi_req_o, 3'h0);
        {able, transmit_queue_empty_i} = 4'hF;
        repeat (8) @(negedge clk_i);
        chk(lpi_req_o, 3'h0);
        $display("idle timer done");
    endtask
    // Threshold 4 units is 512 bytes: equal does not trip, one more does
    task t_term;
        @(negedge clk_i) buffer_load_i = {16'd0, 16'd512, 16'd0};
        @(negedge clk_i) chk(lpi_terminate_o, 0);
        buffer_load_i[31:16] = 16'd513;
        @(negedge clk_i) chk(lpi_terminate_o, 1);
        wr(8'hF6, 8'h05);
        @(negedge clk_i) chk(lpi_terminate_o, 0);
        wr(8'hF7, 8'hFF);
        rd(8'hF7, 8'h00);
        $display("buffer load done");
    endtask
    // Run needs about 130 cycles; stop a hang well past that
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(negedge clk_i);
        reset_n_i = 1;
        t_reset();
        t_np();
        t_recov();
        t_idle();
        t_term();
        conclude();
    end
endmodule // eee_lpi_timing_control_tb_top
